/* File: common/afs_pkg.sv */
// package for the arithmetic fault sequencer: page-zero pointers, float
// status word layout, register offsets, carrier types and state names.
// assumes a 32-bit datapath with bit 0 as the least significant bit.
`default_nettype none
package afs_pkg;
  // page-zero handler pointer locations (octal 37, 45, 46)
  localparam logic [7:0]  PTR_FIXED   = 8'h1f;
  localparam logic [7:0]  PTR_FLOAT   = 8'h25;
  localparam logic [7:0]  PTR_DEC     = 8'h26;
  // wide decimal fault code marker and wide-handler opcode pattern
  localparam logic [15:0] DEC_WIDE    = 16'h8000;
  localparam logic [3:0]  WIDE_OPC    = 4'h8;
  // return block lengths and stack steps
  localparam logic [2:0]  WIDE_LEN    = 3'h6;
  localparam logic [2:0]  NARROW_LEN  = 3'h5;
  localparam logic [31:0] WIDE_STEP   = 32'h0000_0002;
  localparam logic [31:0] NARROW_STEP = 32'h0000_0001;
  // float status word bit positions
  localparam int FSW_ANY = 15;
  localparam int FSW_OVF = 14;
  localparam int FSW_UNF = 13;
  localparam int FSW_INV = 12;
  localparam int FSW_MOF = 11;
  localparam int FSW_TE  = 10;
  localparam int FSW_ARG = 0;           // 4-bit argument error code
  localparam logic [15:0] FSW_RESET = 16'h0000;
  // register offsets
  localparam logic [3:0]  REG_FSW  = 4'h0;
  localparam logic [3:0]  REG_STAT = 4'h4;
  localparam logic [3:0]  REG_VEC  = 4'h8;

  typedef enum logic [1:0] {K_FIXED, K_FLOAT, K_DEC} afs_kind_e;
  typedef enum logic [1:0] {FE_OVF, FE_UNF, FE_INV, FE_MOF} afs_ferr_e;
  typedef enum {S_IDLE, S_PUSH, S_PTR, S_HEAD, S_DONE} afs_state_e;

  // memory request carrier
  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;
    logic [31:0] addr;
    logic [31:0] wdata;
  } afs_mem_s;

  // processor context presented by the datapath at instruction end
  typedef struct packed {
    logic [15:0] psw;
    logic [31:0] ac0;
    logic [31:0] ac1;
    logic [31:0] ac2;
    logic [31:0] ac3;
    logic        carry;
    logic [30:0] pc_next;
    logic [30:0] pc_fault;
  } afs_ctx_s;
endpackage : afs_pkg
`default_nettype wire

/* File: rtl/afs_sequencer.sv */
// arithmetic fault sequencer: fixed, float and decimal fault service.
// assumes the datapath holds the context steady while busy_o is high
// and that memory answers each request with a one-cycle mem_ack_i.
//
// Functional notes
// - overflow flag with trap mask set starts fixed fault at instruction end.
// - fixed fault loads faulting address into accumulator zero, clears status.
// - fixed fault vectors through pointer at location 37 octal.
// - float errors come from divide by zero, overflow, bad special argument.
// - float error sets its own flag and the summary flag.
// - bad argument error also stores argument error code.
// - trap-on op sets trap enable, trap-off op clears it.
// - trap enable zero ignores error; one starts fault at float end.
// - handler first word picks wide or narrow block via pointer 45.
// - wide float block: status, four accumulators, carry plus next address.
// - narrow float block: low accumulator halves, carry plus 15 address bits.
// - after float push clear trap enable; wide fault also clears status.
// - both float widths vector through pointer at 45 octal.
// - bad decimal type or data raises decimal fault at instruction end.
// - wide decimal instructions push wide block, compatible ones narrow.
// - decimal fault clears status, code to accumulator one, address to zero.
// - both decimal widths vector through pointer at 46 octal.
// - narrow codes 0 to 7, wide codes with top bit set.
// - codes 1 to 4 come from the datapath condition unchanged.
// - codes 5 to 7 likewise; code 5 only narrow.
// - wide type 1 block: status, accumulators, undefined word, carry and pc.
// - wide type 2 block: status, pointer, descriptor, two undefined, pc.
// - wide type 3 block: status, four accumulators, carry and pc.
// - decimal push leaves accumulators alone except accumulators zero and one.
// - narrow decimal faults touch only low halves of accumulators.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`default_nettype none
module afs_sequencer
  import afs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire afs_ctx_s    ctx_i,
  input  wire logic [2:0]  seg_i,
  input  wire logic [31:0] wsp_i,
  input  wire logic [31:0] nsp_i,
  input  wire logic        fx_end_i,
  input  wire logic        ovf_flag_i,
  input  wire logic        ovf_mask_i,
  input  wire logic        fp_end_i,
  input  wire logic        fp_err_i,
  input  wire afs_ferr_e   fp_err_kind_i,
  input  wire logic [3:0]  fp_arg_code_i,
  input  wire logic        fp_trap_on_i,
  input  wire logic        fp_trap_off_i,
  input  wire logic        dec_end_i,
  input  wire logic        dec_bad_i,
  input  wire logic        dec_wide_i,
  input  wire logic [1:0]  dec_type_i,
  input  wire logic [2:0]  dec_code_i,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output afs_mem_s         mem_o,
  output logic             busy_o,
  output logic             psw_clr_o,
  output logic             ac0_ld_o,
  output logic [31:0]      ac0_val_o,
  output logic             ac1_ld_o,
  output logic [31:0]      ac1_val_o,
  output logic             ac_low_only_o,
  output logic             sp_upd_o,
  output logic [31:0]      wsp_o,
  output logic [31:0]      nsp_o,
  output logic             vec_o,
  output logic [31:0]      vec_pc_o,
  output logic [31:0]      reg_rdata_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // page-zero word address in the current segment
  function automatic logic [31:0] page0(input logic [2:0] s,
                                        input logic [7:0] loc);
    page0 = {1'b0, s, 20'h00000, loc};
  endfunction : page0

  // return block entry by index
  function automatic logic [31:0] entry(input afs_ctx_s c,
      input afs_kind_e k, input logic w, input logic [1:0] t,
      input logic [2:0] i);
    logic [31:0] e;
    e = 32'h0000_0000;
    if (w) begin
      case (i)
        3'h0:    e = {c.psw, 16'h0000};
        3'h1:    e = c.ac0;
        3'h2:    e = c.ac1;
        3'h3:    e = (k == K_DEC && t == 2'h2) ? 32'h0000_0000 : c.ac2;
        3'h4:    e = (k == K_DEC && t != 2'h3) ? 32'h0000_0000 : c.ac3;
        default: e = {c.carry, (k == K_DEC) ? c.pc_fault : c.pc_next};
      endcase
    end else begin
      case (i)
        3'h0:    e = {16'h0000, c.ac0[15:0]};
        3'h1:    e = {16'h0000, c.ac1[15:0]};
        3'h2:    e = {16'h0000, c.ac2[15:0]};
        3'h3:    e = {16'h0000, c.ac3[15:0]};
        default: e = {16'h0000, c.carry,
                      (k == K_DEC) ? c.pc_fault[14:0] : c.pc_next[14:0]};
      endcase
    end
    entry = e;
  endfunction : entry

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  afs_state_e  state_q;
  afs_kind_e   kind_q;
  afs_ctx_s    ctx_q;
  logic        wide_q;
  logic        ptr_done_q;
  logic [1:0]  dtype_q;
  logic [2:0]  code_q;
  logic [2:0]  idx_q;
  logic [15:0] ptr_q;
  logic [15:0] fsw_q;
  logic        fp_pend_q;
  logic [2:0]  push_cnt_q;
  logic [31:0] new_sp;
  logic        start_fx;
  logic        start_fp;
  logic        start_dec;
  logic        fsw_wr;

  assign start_fx  = fx_end_i & ovf_flag_i & ovf_mask_i;
  // float start needs enable and a raised flag
  assign start_fp  = fp_end_i & fsw_q[FSW_TE] & (fp_pend_q | fp_err_i);
  assign start_dec = dec_end_i & dec_bad_i;
  assign fsw_wr    = reg_wr_i && reg_addr_i == REG_FSW;
  // next stack slot for the selected stack
  assign new_sp    = wide_q ? wsp_o + WIDE_STEP : nsp_o + NARROW_STEP;

  // ---------------------------------------------------------------
  // float status word
  // ---------------------------------------------------------------
  // hardware sets win over software writes in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fsw_q <= FSW_RESET;
    end else begin
      logic [15:0] f;
      f = fsw_wr ? reg_wdata_i[15:0] : fsw_q;
      if (fp_trap_on_i) begin
        f[FSW_TE] = 1'b1;
      end else if (fp_trap_off_i) begin
        f[FSW_TE] = 1'b0;
      end
      // trap enable dropped after float push
      if (state_q == S_DONE && kind_q == K_FLOAT) begin
        f[FSW_TE] = 1'b0;
      end
      if (fp_err_i) begin
        f[FSW_ANY] = 1'b1;
        case (fp_err_kind_i)
          FE_OVF:  f[FSW_OVF] = 1'b1;
          FE_UNF:  f[FSW_UNF] = 1'b1;
          FE_INV:  f[FSW_INV] = 1'b1;
          default: f[FSW_MOF] = 1'b1;
        endcase
        if (fp_err_kind_i == FE_INV) begin
          f[FSW_ARG+:4] = fp_arg_code_i;
        end
      end
      fsw_q <= f;
    end
  end

  // remember a trapping error until the float op ends
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fp_pend_q <= 1'b0;
    end else if (fp_end_i) begin
      fp_pend_q <= 1'b0;
    end else if (fp_err_i && fsw_q[FSW_TE]) begin
      fp_pend_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q    <= S_IDLE;
      kind_q     <= K_FIXED;
      ctx_q      <= '0;
      wide_q     <= 1'b0;
      ptr_done_q <= 1'b0;
      dtype_q    <= 2'h0;
      code_q     <= 3'h0;
      idx_q      <= 3'h0;
      ptr_q      <= 16'h0000;
      mem_o      <= '0;
      wsp_o      <= 32'h0000_0000;
      nsp_o      <= 32'h0000_0000;
    end else begin
      case (state_q)
        S_IDLE: begin
          idx_q      <= 3'h0;
          ptr_done_q <= 1'b0;
          ctx_q      <= ctx_i;
          wsp_o      <= wsp_i;
          nsp_o      <= nsp_i;
          dtype_q    <= dec_type_i;
          code_q     <= dec_code_i;
          if (start_fx) begin
            kind_q  <= K_FIXED;
            wide_q  <= 1'b1;
            state_q <= S_PUSH;
          end else if (start_fp) begin
            kind_q  <= K_FLOAT;
            state_q <= S_PTR;
          end else if (start_dec) begin
            kind_q  <= K_DEC;
            wide_q  <= dec_wide_i;
            state_q <= S_PUSH;
          end
        end
        S_PUSH: begin
          // one entry per write, pointer advanced first
          if (!mem_o.req) begin
            mem_o.req   <= 1'b1;
            mem_o.we    <= 1'b1;
            mem_o.wide  <= wide_q;
            mem_o.addr  <= new_sp;
            mem_o.wdata <= entry(ctx_q, kind_q, wide_q, dtype_q, idx_q);
          end else if (mem_ack_i) begin
            mem_o.req <= 1'b0;
            if (wide_q) begin
              wsp_o <= new_sp;
            end else begin
              nsp_o <= new_sp;
            end
            idx_q <= idx_q + 3'h1;
            if (idx_q == (wide_q ? WIDE_LEN : NARROW_LEN) - 3'h1) begin
              state_q <= ptr_done_q ? S_DONE : S_PTR;
            end
          end
        end
        S_PTR: begin
          if (!mem_o.req) begin
            mem_o.req  <= 1'b1;
            mem_o.we   <= 1'b0;
            mem_o.wide <= 1'b0;
            case (kind_q)
              K_FIXED: mem_o.addr <= page0(seg_i, PTR_FIXED);
              K_FLOAT: mem_o.addr <= page0(seg_i, PTR_FLOAT);
              default: mem_o.addr <= page0(seg_i, PTR_DEC);
            endcase
          end else if (mem_ack_i) begin
            mem_o.req  <= 1'b0;
            ptr_q      <= mem_rdata_i[15:0];
            ptr_done_q <= 1'b1;
            state_q    <= (kind_q == K_FLOAT) ? S_HEAD : S_DONE;
          end
        end
        S_HEAD: begin
          if (!mem_o.req) begin
            mem_o.req  <= 1'b1;
            mem_o.we   <= 1'b0;
            mem_o.addr <= {1'b0, seg_i, 12'h000, ptr_q};
          end else if (mem_ack_i) begin
            mem_o.req <= 1'b0;
            // wide when msb set and low nibble matches
            wide_q  <= mem_rdata_i[15] && mem_rdata_i[3:0] == WIDE_OPC;
            state_q <= S_PUSH;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // completion pulses to the datapath
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_o         <= 1'b0;
      vec_pc_o      <= 32'h0000_0000;
      psw_clr_o     <= 1'b0;
      ac0_ld_o      <= 1'b0;
      ac0_val_o     <= 32'h0000_0000;
      ac1_ld_o      <= 1'b0;
      ac1_val_o     <= 32'h0000_0000;
      ac_low_only_o <= 1'b0;
      sp_upd_o      <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      vec_o     <= state_q == S_DONE;
      sp_upd_o  <= state_q == S_DONE;
      busy_o    <= state_q != S_IDLE ? state_q != S_DONE
                 : (start_fx | start_fp | start_dec);
      vec_pc_o  <= {1'b0, seg_i, 12'h000, ptr_q};
      // status cleared except for narrow float
      psw_clr_o <= state_q == S_DONE && (kind_q != K_FLOAT || wide_q);
      ac0_ld_o  <= state_q == S_DONE && kind_q != K_FLOAT;
      ac0_val_o <= {1'b0, ctx_q.pc_fault};
      // only accumulator one gets the code
      ac1_ld_o  <= state_q == S_DONE && kind_q == K_DEC;
      ac1_val_o <= {ctx_q.ac1[31:16],
                    (wide_q ? DEC_WIDE : 16'h0000) | {13'h0000, code_q}};
      // narrow decimal writes only low halves
      ac_low_only_o <= kind_q == K_DEC && !wide_q;
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == REG_FSW) begin
        reg_rdata_o <= {16'h0000, fsw_q};
      end else if (reg_addr_i == REG_STAT) begin
        reg_rdata_o <= {24'h000000, busy_o, wide_q, kind_q, 1'b0, code_q};
      end else if (reg_addr_i == REG_VEC) begin
        reg_rdata_o <= vec_pc_o;
      end else begin
        reg_rdata_o <= 32'h0000_0000;
      end
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // entries written in the current fault
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_cnt_q <= 3'h0;
    end else if (state_q == S_IDLE) begin
      push_cnt_q <= 3'h0;
    end else if (state_q == S_PUSH && mem_o.req && mem_ack_i) begin
      push_cnt_q <= push_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  fixed_start_a: assert property (
    state_q == S_IDLE && start_fx |=> busy_o && kind_q == K_FIXED)
    else $error("fixed fault not started");
  block_len_a: assert property (
    state_q == S_DONE |-> push_cnt_q == (wide_q ? 3'h6 : 3'h5))
    else $error("wrong return block length");
  fix_ptr_a: assert property (
    state_q == S_PTR && mem_o.req && kind_q == K_FIXED
    |-> mem_o.addr[7:0] == 8'h1f)
    else $error("fixed pointer location wrong");
  float_ptr_a: assert property (
    state_q == S_PTR && mem_o.req && kind_q == K_FLOAT
    |-> mem_o.addr[7:0] == 8'h25)
    else $error("float pointer location wrong");
  any_flag_a: assert property (
    fp_err_i |=> fsw_q[FSW_ANY])
    else $error("summary flag not set");
  trap_on_a: assert property (
    fp_trap_on_i && !(state_q == S_DONE && kind_q == K_FLOAT)
    |=> fsw_q[FSW_TE])
    else $error("trap enable not set");
  te_clear_a: assert property (
    state_q == S_DONE && kind_q == K_FLOAT |=> !fsw_q[FSW_TE] ##0 vec_o
    ##0 psw_clr_o == wide_q)
    else $error("float completion wrong");
  dec_code_a: assert property (
    state_q == S_DONE && kind_q == K_DEC |=> ac1_ld_o && ac0_ld_o
    && ac1_val_o[15] == wide_q && psw_clr_o)
    else $error("decimal completion wrong");
  wsp_step_a: assert property (
    state_q == S_PUSH && mem_o.req && mem_ack_i && wide_q
    |=> wsp_o == $past(wsp_o) + 32'h2)
    else $error("wide stack step wrong");

  cover_fixed_c:  cover property (vec_o && kind_q == K_FIXED);
  cover_fwide_c:  cover property (vec_o && kind_q == K_FLOAT && wide_q);
  cover_fnarr_c:  cover property (vec_o && kind_q == K_FLOAT && !wide_q);
  cover_decn_c:   cover property (vec_o && kind_q == K_DEC && !wide_q);

endmodule : afs_sequencer
`default_nettype wire

/* File: sim/afs_mem_model.sv */
// stack and page-zero memory model for the arithmetic fault sequencer.
// assumes one outstanding request held until the ack pulse is seen.
`default_nettype none
module afs_mem_model
  import afs_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_b_i,
  input  wire afs_mem_s mem_i,
  input  wire logic     slow_i,
  output logic          ack_o,
  output logic [31:0]   rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // storage and access logs
  // ----------------------------------------------------------------
  logic [31:0] m [logic [31:0]];
  logic [31:0] wa [$];
  logic [31:0] wd [$];
  logic [31:0] ra [$];
  logic [1:0]  wait_q;

  // answer after zero or two wait cycles; data toggles except on a read ack
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 32'h0;
      wait_q  <= 2'h0;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (mem_i.req && !ack_o) begin
        if (slow_i && wait_q != 2'h2) begin
          wait_q <= wait_q + 2'h1;
        end else begin
          ack_o  <= 1'b1;
          wait_q <= 2'h0;
          if (mem_i.we) begin
            wa.push_back(mem_i.addr);
            wd.push_back(mem_i.wdata);
          end else begin
            ra.push_back(mem_i.addr);
            rdata_o <= m.exists(mem_i.addr) ? m[mem_i.addr] : 32'hdead_0000;
          end
        end
      end
    end
  end
endmodule : afs_mem_model
`default_nettype wire

/* File: sim/arith_fault_sequencer_test.sv */
// self-checking bench for the arithmetic fault sequencer.
// assumes afs_pkg and a memory model answering the stack port.
`default_nettype none
module arith_fault_sequencer_test
  import afs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_b_i, fx_end, ovf_flag, ovf_mask, fp_end, fp_err;
  logic trap_on, trap_off, dec_end, dec_bad, dec_wide, mem_ack, slow;
  logic reg_wr, reg_rd, busy, psw_clr, ac0_ld, ac1_ld, low_only, sp_upd;
  logic vec;
  afs_ctx_s    ctx;
  afs_ferr_e   fp_kind;
  afs_mem_s    mem;
  logic [2:0]  seg, dec_code;
  logic [1:0]  dec_type;
  logic [3:0]  fp_arg, reg_addr;
  logic [15:0] ptr;
  logic [31:0] wsp, nsp, mem_rdata, reg_wdata, ac0_val, ac1_val, wsp_o;
  logic [31:0] nsp_o, vec_pc, rdata, d;
  logic [15:0] hw_tbl [4] = '{16'h8008, 16'h8009, 16'h0008, 16'hf7f8};
  int          error_cnt, num_checks, cyc;

  afs_sequencer DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ctx_i(ctx),
    .seg_i(seg), .wsp_i(wsp), .nsp_i(nsp), .fx_end_i(fx_end),
    .ovf_flag_i(ovf_flag), .ovf_mask_i(ovf_mask), .fp_end_i(fp_end),
    .fp_err_i(fp_err), .fp_err_kind_i(fp_kind), .fp_arg_code_i(fp_arg),
    .fp_trap_on_i(trap_on), .fp_trap_off_i(trap_off), .dec_end_i(dec_end),
    .dec_bad_i(dec_bad), .dec_wide_i(dec_wide), .dec_type_i(dec_type),
    .dec_code_i(dec_code), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .mem_o(mem), .busy_o(busy), .psw_clr_o(psw_clr),
    .ac0_ld_o(ac0_ld), .ac0_val_o(ac0_val), .ac1_ld_o(ac1_ld),
    .ac1_val_o(ac1_val), .ac_low_only_o(low_only), .sp_upd_o(sp_upd),
    .wsp_o(wsp_o), .nsp_o(nsp_o), .vec_o(vec), .vec_pc_o(vec_pc),
    .reg_rdata_o(rdata));
  afs_mem_model mem_m (.clk_i(core_clk_i), .rst_b_i(rst_b_i), .mem_i(mem),
    .slow_i(slow), .ack_o(mem_ack), .rdata_o(mem_rdata));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // cut a hang short well above the expected run length
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one-cycle pulse on the chosen event input
  task automatic start(input int s);
    @(posedge core_clk_i);
    case (s)
      0: fx_end <= 1'b1;
      1: fp_end <= 1'b1;
      2: dec_end <= 1'b1;
      3: fp_err <= 1'b1;
      4: trap_on <= 1'b1;
      default: trap_off <= 1'b1;
    endcase
    @(posedge core_clk_i);
    {fx_end, fp_end, dec_end, fp_err, trap_on, trap_off} <= '0;
  endtask : start
  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    @(negedge core_clk_i);
    v = rdata;
  endtask : reg_read
  task automatic idle_check();
    repeat (4) begin
      @(negedge core_clk_i);
      check("busy idle", busy, 32'h0);
    end
  endtask : idle_check
  // fresh context, stacks and page-zero pointer before a fault
  task automatic prep(input logic [7:0] loc, input logic [15:0] hw);
    logic [223:0] r;
    logic [2:0]   sg;
    r  = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
          $urandom};
    sg = 3'($urandom);
    ptr = 16'($urandom) | 16'h8000;
    mem_m.wa.delete(); mem_m.wd.delete(); mem_m.ra.delete();
    mem_m.m[{1'b0, sg, 20'h0, loc}] = {16'h0, ptr};
    mem_m.m[{1'b0, sg, 12'h0, ptr}] = {16'h0, hw};
    @(posedge core_clk_i);
    ctx <= r[206:0]; seg <= sg; slow <= 1'($urandom);
    wsp <= $urandom; nsp <= $urandom;
  endtask : prep
  // expected return block entry i
  function automatic logic [31:0] exp_word(afs_kind_e k, logic w, int i);
    logic [31:0] acs [4];
    logic [30:0] pc;
    acs = '{ctx.ac0, ctx.ac1, ctx.ac2, ctx.ac3};
    pc = (k == K_DEC) ? ctx.pc_fault : ctx.pc_next;
    if (!w) return (i == 4) ? {16'h0, ctx.carry, pc[14:0]}
                            : {16'h0, acs[i][15:0]};
    if (i == 0) return {ctx.psw, 16'h0};
    if (i == 5) return {ctx.carry, pc};
    return acs[i-1];
  endfunction : exp_word
  // undefined entries of decimal blocks are not compared
  function automatic logic defd(afs_kind_e k, logic w, logic [1:0] t, int i);
    if (k != K_DEC) return 1'b1;
    if (!w) return i == 0 || i == 1 || i == 4;
    if (t == 2'h1) return i != 4;
    if (t == 2'h2) return i != 3 && i != 4;
    return 1'b1;
  endfunction : defd
  task automatic serve(input afs_kind_e k, input logic w, input logic [1:0] t,
                       input logic [15:0] code);
    logic [7:0]  loc;
    logic [31:0] step, base, wm;
    int          n, i;
    loc  = k == K_FIXED ? PTR_FIXED : (k == K_FLOAT ? PTR_FLOAT : PTR_DEC);
    step = w ? WIDE_STEP : NARROW_STEP;
    base = w ? wsp : nsp;
    wm   = w ? 32'hffff_ffff : 32'h0000_ffff;
    n    = w ? 6 : 5;
    @(negedge core_clk_i);
    check("busy start", busy, 32'h1);
    for (i = 0; i < 300; i++) begin
      if (vec === 1'b1) break;
      @(negedge core_clk_i);
    end
    check("vector pulse", vec, 32'h1);
    check("busy end", busy, 32'h0);
    check("sp update", sp_upd, 32'h1);
    check("status clear", psw_clr, 32'(!(k == K_FLOAT && !w)));
    check("ac0 load", ac0_ld, 32'(k != K_FLOAT));
    if (k != K_FLOAT) check("ac0 value", ac0_val, {1'b0, ctx.pc_fault});
    check("ac1 load", ac1_ld, 32'(k == K_DEC));
    if (k == K_DEC) check("ac1 code", ac1_val[15:0], code);
    check("low only", low_only, 32'(k == K_DEC && !w));
    check("stack ptr", w ? wsp_o : nsp_o, base + step * 32'(n));
    check("vector pc", vec_pc[15:0], ptr);
    check("ptr read", mem_m.ra[0], {1'b0, seg, 20'h0, loc});
    if (k == K_FLOAT) check("hw read", mem_m.ra[1], {1'b0, seg, 12'h0, ptr});
    check("entry count", mem_m.wa.size(), 32'(n));
    for (i = 0; i < n && i < mem_m.wa.size(); i++) begin
      check("entry addr", mem_m.wa[i], base + step * 32'(i + 1));
      if (defd(k, w, t, i)) check("entry data", mem_m.wd[i] & wm, exp_word(k, w, i) & wm);
    end
  endtask : serve

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b_i, fx_end, ovf_flag, ovf_mask, fp_end, fp_err, trap_on} = '0;
    {trap_off, dec_end, dec_bad, dec_wide, slow, reg_wr, reg_rd} = '0;
    {ctx, seg, dec_code, dec_type, fp_arg, reg_addr, wsp, nsp} = '0;
    fp_kind = FE_OVF; reg_wdata = 32'h0; ptr = 16'h0;
    error_cnt = 0; num_checks = 0; cyc = 0;
    void'($urandom(14));
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    // float status word access and trap enable ops
    reg_write(REG_FSW, 32'h0000_0400);
    reg_read(REG_FSW, d);
    check("fsw write", d, 32'h0000_0400);
    reg_read(4'hc, d);
    check("unmapped", d, 32'h0);
    start(5);
    reg_read(REG_FSW, d);
    check("trap off", d, 32'h0);
    start(4);
    reg_read(REG_FSW, d);
    check("trap on", d, 32'h0000_0400);
    start(5);
    $display("test registers done");
    // every error kind with traps off: flags set, fault ignored
    for (int k = 0; k < 4; k++) begin
      reg_write(REG_FSW, 32'h0);
      fp_kind <= afs_ferr_e'(k);
      fp_arg  <= 4'($urandom) | 4'h1;
      start(3);
      reg_read(REG_FSW, d);
      check("fsw flags", d, 32'h8000 | (32'h4000 >> k) | (k == 2 ? 32'(fp_arg) : 32'h0));
      start(1);
      idle_check();
    end
    reg_write(REG_FSW, 32'h0);
    $display("test float flags done");
    // float faults through wide and narrow handlers
    foreach (hw_tbl[j]) begin
      prep(PTR_FLOAT, hw_tbl[j]);
      start(4);
      fp_kind <= afs_ferr_e'($urandom % 4);
      start(3);
      start(1);
      serve(K_FLOAT, hw_tbl[j][15] && hw_tbl[j][3:0] == WIDE_OPC, 2'h0, 16'h0);
      reg_read(REG_FSW, d);
      check("trap cleared", d[FSW_TE], 32'h0);
      reg_read(REG_VEC, d);
      check("vec reg", d, {1'b0, seg, 12'h0, ptr});
    end
    $display("test float faults done");
    // fixed overflow: masked first, then serviced twice
    ovf_flag <= 1'b1;
    start(0);
    idle_check();
    ovf_mask <= 1'b1;
    repeat (2) begin
      prep(PTR_FIXED, 16'h0);
      start(0);
      serve(K_FIXED, 1'b1, 2'h0, 16'h0);
    end
    {ovf_flag, ovf_mask} <= 2'b00;
    $display("test fixed faults done");
    // decimal: good data ignored, then every code in both widths except wide code 5
    dec_bad <= 1'b0;
    start(2);
    idle_check();
    for (int c = 0; c < 8; c++) begin
      for (int w = 0; w < 2; w++) begin
        if (c == 5 && w == 1) continue;
        prep(PTR_DEC, 16'h0);
        dec_bad <= 1'b1; dec_wide <= 1'(w); dec_code <= 3'(c);
        dec_type <= 2'($urandom % 3 + 1);
        start(2);
        serve(K_DEC, 1'(w), dec_type, w ? (DEC_WIDE | 16'(c)) : 16'(c));
        reg_read(REG_STAT, d);
        check("stat reg", d, {25'h0, 1'(w), 2'h2, 1'b0, 3'(c)});
      end
    end
    $display("test decimal faults done");
    end_of_test();
  end
endmodule : arith_fault_sequencer_test
`default_nettype wire
